// *** buck_converter_control_regs.v ***
// Functional notes
// - The five converter registers sit at consecutive addresses 0x35 to 0x39.
// - Run-voltage bits 5:0 are a read-write code, reset zero, used in normal operation.
// - Run-voltage bit 6 is read-only range, loaded only from one-time or trial setup.
// - Standby-voltage bits 5:0 are a read-write code, reset zero, used in standby.
// - Standby-voltage bit 6 reads back the range bit loaded at configuration.
// - Sleep-voltage bits 5:0 are a read-write code, reset zero, used in sleep.
// - Sleep-voltage bit 6 reads back the range bit loaded at configuration.
// - Mode register bits 3:0 are the read-write switching mode field.
// - Mode bit 5, reset zero, keeps the converter in pulse-frequency mode during sleep.
// - Config bit 0, reset zero, picks the low current limit when set.
// - Config bits 3:2 are the read-write switching frequency selector.
// - Config bits 5:4 select the phase clock.
// - Config bits 7:6 select the voltage scaling step speed.
`include "buck_regs_consts.vh"
`default_nettype none
module buck_converter_control_regs (
    input wire core_clk,
    input wire rst_n,
    input wire [7:0] regAddr,
    input wire [7:0] regWriteData,
    input wire regWriteStrobe,
    input wire regReadStrobe,
    input wire rangeLoadStrobe,
    input wire rangeLoadValue,
    input wire [1:0] powerState,
    output reg [7:0] regReadData,
    output reg regHit,
    output reg [5:0] activeVoltageCode,
    output reg voltageRange,
    output reg converterEnable,
    output reg [3:0] switchingMode,
    output reg forcePfm,
    output reg currentLimitLow,
    output reg [1:0] switchFreqSelect,
    output reg [1:0] phaseClockSelect,
    output reg [1:0] voltageSlewSpeed
);
    reg [5:0] runVoltageCode;
    reg [5:0] standbyVoltageCode;
    reg [5:0] sleepVoltageCode;
    reg [3:0] switchingModeField;
    reg sleepKeepAlive;
    reg [7:0] converterConfig;
    reg rangeBit;
    reg [7:0] next_readData;

    // address decode used by both the write path and the regHit flag; the read mux cases on regAddr itself
    function inRange;
        input [7:0] a;
        begin
            inRange = (a >= `ADDR_RUN_VOLTAGE) && (a <= `ADDR_CONFIG);
        end
    endfunction

    // one decoder feeds every write enable so a stray address cannot reach two registers
    function writeHits;
        input strobe;
        input [7:0] a;
        input [7:0] target;
        begin
            writeHits = strobe && inRange(a) && (a == target);
        end
    endfunction

    always @(posedge core_clk) begin
        if (!rst_n) begin
            runVoltageCode <= `VCODE_RESET;
        end else if (writeHits(regWriteStrobe, regAddr, `ADDR_RUN_VOLTAGE)) begin
            runVoltageCode <= regWriteData[`VCODE_MSB:0];
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            standbyVoltageCode <= `VCODE_RESET;
        end else if (writeHits(regWriteStrobe, regAddr, `ADDR_STANDBY_VOLTAGE)) begin
            standbyVoltageCode <= regWriteData[`VCODE_MSB:0];
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            sleepVoltageCode <= `VCODE_RESET;
        end else if (writeHits(regWriteStrobe, regAddr, `ADDR_SLEEP_VOLTAGE)) begin
            sleepVoltageCode <= regWriteData[`VCODE_MSB:0];
        end
    end

    // bits 4, 6 and 7 of the mode byte are dropped here, so they read back zero
    always @(posedge core_clk) begin
        if (!rst_n) begin
            switchingModeField <= `MODE_RESET;
            sleepKeepAlive <= 1'b0;
        end else if (writeHits(regWriteStrobe, regAddr, `ADDR_MODE_SELECT)) begin
            switchingModeField <= regWriteData[`MODE_MSB:0];
            sleepKeepAlive <= regWriteData[`KEEP_ALIVE_BIT];
        end
    end

    // bit 1 is kept as plain storage; nothing downstream reads it
    always @(posedge core_clk) begin
        if (!rst_n) begin
            converterConfig <= `CONFIG_RESET;
        end else if (writeHits(regWriteStrobe, regAddr, `ADDR_CONFIG)) begin
            converterConfig <= regWriteData;
        end
    end

    // range is never host-writable; only the configuration load touches it
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rangeBit <= 1'b0;
        end else if (rangeLoadStrobe) begin
            rangeBit <= rangeLoadValue;
        end
    end

    always @* begin
        case (regAddr)
            `ADDR_RUN_VOLTAGE: next_readData = {1'b0, rangeBit, runVoltageCode};
            `ADDR_STANDBY_VOLTAGE: next_readData = {1'b0, rangeBit, standbyVoltageCode};
            `ADDR_SLEEP_VOLTAGE: next_readData = {1'b0, rangeBit, sleepVoltageCode};
            `ADDR_MODE_SELECT: next_readData = {2'b00, sleepKeepAlive, 1'b0, switchingModeField};
            `ADDR_CONFIG: next_readData = converterConfig;
            default: next_readData = 8'h00;
        endcase
    end

    // read data holds between reads so a slow engine can fetch it late
    always @(posedge core_clk) begin
        if (!rst_n) begin
            regReadData <= 8'h00;
        end else if (regReadStrobe) begin
            regReadData <= next_readData;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            regHit <= 1'b0;
        end else begin
            regHit <= (regReadStrobe || regWriteStrobe) && inRange(regAddr);
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            voltageRange <= 1'b0;
        end else begin
            voltageRange <= rangeBit;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            switchingMode <= `MODE_RESET;
        end else begin
            switchingMode <= switchingModeField;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            currentLimitLow <= 1'b0;
        end else begin
            currentLimitLow <= converterConfig[`ILIM_BIT];
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            switchFreqSelect <= 2'b00;
        end else begin
            switchFreqSelect <= converterConfig[`FREQ_LSB+1:`FREQ_LSB];
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            phaseClockSelect <= 2'b00;
        end else begin
            phaseClockSelect <= converterConfig[`PHASE_LSB+1:`PHASE_LSB];
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            voltageSlewSpeed <= 2'b00;
        end else begin
            voltageSlewSpeed <= converterConfig[`SLEW_LSB+1:`SLEW_LSB];
        end
    end

    reg [5:0] next_activeVoltageCode;
    reg next_converterEnable;
    reg next_forcePfm;

    // state 3 is not used by the sequencer; treating it as run keeps the rail up
    always @* begin
        next_activeVoltageCode = runVoltageCode;
        next_converterEnable = 1'b1;
        next_forcePfm = 1'b0;
        case (powerState)
            `PSTATE_STANDBY: begin
                next_activeVoltageCode = standbyVoltageCode;
            end
            `PSTATE_SLEEP: begin
                next_activeVoltageCode = sleepVoltageCode;
                next_converterEnable = sleepKeepAlive;
                next_forcePfm = sleepKeepAlive;
            end
            default: begin
                next_activeVoltageCode = runVoltageCode;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            activeVoltageCode <= `VCODE_RESET;
            converterEnable <= 1'b0;
            forcePfm <= 1'b0;
        end else begin
            activeVoltageCode <= next_activeVoltageCode;
            converterEnable <= next_converterEnable;
            forcePfm <= next_forcePfm;
        end
    end
endmodule // buck_converter_control_regs
`default_nettype wire

// *** buck_converter_control_regs_tb.sv ***
`default_nettype none
module buck_converter_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, rst_n = 0, rangeLoadStrobe = 0, rangeLoadValue = 0;
    logic [1:0] powerState = 2'h0;
    wire logic [7:0] regAddr, regWriteData, regReadData;
    wire logic regWriteStrobe, regReadStrobe, regHit, voltageRange, converterEnable, forcePfm;
    wire logic currentLimitLow;
    wire logic [5:0] activeVoltageCode;
    wire logic [3:0] switchingMode;
    wire logic [1:0] switchFreqSelect, phaseClockSelect, voltageSlewSpeed;
    int numErrors = 0, testsRun = 0;
    buck_converter_control_regs u_buck_converter_control_regs (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .regAddr(regAddr),
        .regWriteData(regWriteData),
        .regWriteStrobe(regWriteStrobe),
        .regReadStrobe(regReadStrobe),
        .rangeLoadStrobe(rangeLoadStrobe),
        .rangeLoadValue(rangeLoadValue),
        .powerState(powerState),
        .regReadData(regReadData),
        .regHit(regHit),
        .activeVoltageCode(activeVoltageCode),
        .voltageRange(voltageRange),
        .converterEnable(converterEnable),
        .switchingMode(switchingMode),
        .forcePfm(forcePfm),
        .currentLimitLow(currentLimitLow),
        .switchFreqSelect(switchFreqSelect),
        .phaseClockSelect(phaseClockSelect),
        .voltageSlewSpeed(voltageSlewSpeed)
    );
    host_model u_host_model (
        .core_clk(core_clk),
        .regAddr(regAddr),
        .regWriteData(regWriteData),
        .regWriteStrobe(regWriteStrobe),
        .regReadStrobe(regReadStrobe)
    );
    initial forever #25 core_clk = ~core_clk;
    task automatic chk(input logic [7:0] got, exp);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, e);
        u_host_model.xfer(a, 8'h00, 1'b0);
        chk(regReadData, e);
        chk({7'h0, regHit}, {7'h0, a inside {[8'h35:8'h39]}});
    endtask
    task automatic st(input logic [1:0] s);
        @(posedge core_clk);
        powerState <= s;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic tRegs();
        logic [23:0] tbl [8] = '{24'h35ff7f, 24'h362a6a, 24'h371555, 24'h38ff2f,
            24'h395555, 24'h39aaaa, 24'h34ff00, 24'h3aff00};
        for (int a = 8'h35; a < 8'h3a; a++)
            rd(8'(a), 8'h00);
        @(posedge core_clk);
        {rangeLoadStrobe, rangeLoadValue} <= 2'b11;
        @(posedge core_clk);
        rangeLoadStrobe <= 1'b0;
        foreach (tbl[i]) begin
            u_host_model.xfer(tbl[i][23:16], tbl[i][15:8], 1'b1);
            rd(tbl[i][23:16], tbl[i][7:0]);
        end
        $display("register test done");
    endtask
    task automatic tOut();
        st(2'h1);
        chk({2'h0, activeVoltageCode}, 8'h2a);
        st(2'h2);
        chk({activeVoltageCode, converterEnable, forcePfm}, 8'h57);
        chk({switchingMode, voltageSlewSpeed, phaseClockSelect}, 8'hfa);
        chk({5'h0, switchFreqSelect, currentLimitLow}, 8'h04);
        chk({7'h0, voltageRange}, 8'h01);
        u_host_model.xfer(8'h38, 8'h00, 1'b1);
        st(2'h2);
        chk({6'h0, converterEnable, forcePfm}, 8'h00);
        st(2'h0);
        chk({activeVoltageCode, converterEnable, forcePfm}, 8'hfe);
        $display("output test done");
    endtask
    task automatic conclude();
        $display("%0d checks, %0d errors", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        tRegs();
        tOut();
        conclude();
    end
endmodule // buck_converter_control_regs_tb
bind buck_converter_control_regs buck_regs_checker u_buck_regs_checker (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .regWriteStrobe(regWriteStrobe),
    .regReadStrobe(regReadStrobe),
    .rangeLoadStrobe(rangeLoadStrobe),
    .regHit(regHit),
    .voltageRange(voltageRange),
    .converterEnable(converterEnable),
    .forcePfm(forcePfm),
    .currentLimitLow(currentLimitLow),
    .regAddr(regAddr),
    .regWriteData(regWriteData),
    .regReadData(regReadData),
    .powerState(powerState),
    .switchFreqSelect(switchFreqSelect)
);
`default_nettype wire

// *** buck_regs_checker.sv ***
`default_nettype none
module buck_regs_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic regWriteStrobe,
    input wire logic regReadStrobe,
    input wire logic rangeLoadStrobe,
    input wire logic regHit,
    input wire logic voltageRange,
    input wire logic converterEnable,
    input wire logic forcePfm,
    input wire logic currentLimitLow,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic [7:0] regReadData,
    input wire logic [1:0] powerState,
    input wire logic [1:0] switchFreqSelect
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire hit = regAddr inside {[8'h35:8'h39]}, acc = regWriteStrobe || regReadStrobe;
    wire rdX = regReadStrobe && !hit, rdV = regReadStrobe && regAddr inside {[8'h35:8'h37]};
    wire cfgWr = regWriteStrobe && regAddr == 8'h39, slp = powerState == 2'h2;
    map_hit_a: assert property (acc && hit |=> regHit) else $error("no hit");
    miss_rd_a: assert property (rdX |=> !regHit && !regReadData) else $error("miss");
    range_rd_a: assert property (rdV |=> regReadData[7:6] == {1'b0, voltageRange})
        else $error("range bit wrong");
    // four quiet cycles cover load latency through two flops
    range_hold_a: assert property (!rangeLoadStrobe [*4] |-> $stable(voltageRange))
        else $error("range moved");
    sleep_out_a: assert property (slp [*3] |-> converterEnable == forcePfm)
        else $error("sleep outputs wrong");
    run_out_a: assert property (!slp [*3] |-> converterEnable && !forcePfm)
        else $error("run outputs wrong");
    ilim_wr_a: assert property (cfgWr |=> ##1 currentLimitLow == $past(regWriteData[0], 2))
        else $error("limit not applied");
    freq_wr_a: assert property (cfgWr |-> ##2 switchFreqSelect == $past(regWriteData[3:2], 2))
        else $error("frequency not applied");
    cover property (regReadStrobe && hit ##1 regHit);
    cover property (slp && forcePfm);
    cover property (rangeLoadStrobe);
endmodule // buck_regs_checker
`default_nettype wire

// *** buck_regs_consts.vh ***
`ifndef BUCK_REGS_CONSTS_VH
`define BUCK_REGS_CONSTS_VH
`define ADDR_RUN_VOLTAGE 8'h35
`define ADDR_STANDBY_VOLTAGE 8'h36
`define ADDR_SLEEP_VOLTAGE 8'h37
`define ADDR_MODE_SELECT 8'h38
`define ADDR_CONFIG 8'h39
`define VCODE_MSB 5
`define VCODE_RESET 6'h00
`define RANGE_BIT 6
`define MODE_MSB 3
`define MODE_RESET 4'h0
`define KEEP_ALIVE_BIT 5
`define ILIM_BIT 0
`define FREQ_LSB 2
`define PHASE_LSB 4
`define SLEW_LSB 6
`define CONFIG_RESET 8'h00
`define PSTATE_RUN 2'h0
`define PSTATE_STANDBY 2'h1
`define PSTATE_SLEEP 2'h2
`endif

// *** host_model.sv ***
`default_nettype none
module host_model (
    input wire logic core_clk,
    output logic [7:0] regAddr,
    output logic [7:0] regWriteData,
    output logic regWriteStrobe,
    output logic regReadStrobe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {regAddr, regWriteData, regWriteStrobe, regReadStrobe} = 18'h0;
    // voltage codes fit six bits, so the low set point range is kept
    task automatic xfer(input logic [7:0] a, d, input logic w);
        @(posedge core_clk);
        {regAddr, regWriteData, regWriteStrobe, regReadStrobe} <= {a, d, w, !w};
        @(posedge core_clk);
        // released address and data lines invert and both strobes drop, so a stale value cannot pass
        {regAddr, regWriteData, regWriteStrobe, regReadStrobe} <= {~a, ~d, 2'b00};
        #1;
    endtask
endmodule // host_model
`default_nettype wire
